/* rtl/spg_params.svh */
`ifndef SPG_PARAMS_SVH
`define SPG_PARAMS_SVH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define SPG_OP_WRITE_ENABLE 8'h06
`define SPG_OP_WRITE_DISABLE 8'h04
`define SPG_OP_STATUS_WRITE 8'h01
`define SPG_OP_PROT_READ 8'h3C

// ----------------------------------------------------------------
// status byte layout
// ----------------------------------------------------------------
`define SPG_LOCK_BIT 7
`define SPG_GLOB_HI 5
`define SPG_GLOB_LO 2
`define SPG_GLOB_ALL_SET 4'hF
`define SPG_GLOB_ALL_CLR 4'h0
`define SPG_STAT_RESET 8'h0C
// synchroniser reset: cs_n high, sck low, si low, wp_n high
`define SPG_SYNC_RESET 4'h9
// previous cs_n high, previous sck low: matches the idle pins
`define SPG_EDGE_RESET 2'h2

// ----------------------------------------------------------------
// sector map and framing
// ----------------------------------------------------------------
`define SPG_SEC_CNT 8
`define SPG_SEC_HI 18
`define SPG_SEC_LO 16
`define SPG_LAST_BIT 3'h7
`define SPG_BYTE_OPCODE 3'h0
`define SPG_BYTE_DATA 3'h1
`define SPG_BYTE_ADDR_LAST 3'h3
`define SPG_BYTE_SAT 3'h4
`define SPG_SWP_NONE 2'h0
`define SPG_SWP_SOME 2'h1
`define SPG_SWP_ALL 2'h3

`endif

/* rtl/spg_pkg.sv */
package spg_pkg;
   typedef logic [7:0] spg_byte_t;
   typedef logic [2:0] spg_cnt_t;
endpackage : spg_pkg

/* rtl/spg_prot_ctrl.sv */
// Overview of operation
// - all-ones bits 5..2 protect every sector
// - all-zeros bits 5..2 unprotect every sector
// - mixed bits 5..2 leave sectors alone
// - pin low, lock set: nothing changes
// - pin high, lock set: only unlock
// - unlocked 00h/7Fh: global op, lock stays
// - unlocked FFh: protect all and lock
// - 0Fh unlocks, F0h locks, sectors untouched
// - only bit 7 is stored
// - status bits 4..2 show pin and summary
// - then repeating FFh or 00h output
// - deselect ends read, output released
// - read data ignores write-protect pin
// - summary shows all, some or none
// - status write needs write latch set
// - reset leaves every sector protected
`timescale 1ns/100ps
`include "spg_params.svh"
module spg_prot_ctrl (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic si_i,
   input wire logic wp_n_i,
   output logic so_o,
   output logic so_oe_o,
   output logic [7:0] status_o,
   output logic [`SPG_SEC_CNT-1:0] sector_prot_o
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [1:0] swp_of(
      input logic [`SPG_SEC_CNT-1:0] s);
      if (&s) swp_of = `SPG_SWP_ALL;
      else if (|s) swp_of = `SPG_SWP_SOME;
      else swp_of = `SPG_SWP_NONE;
   endfunction : swp_of

   function automatic logic [3:0] glob_of(input spg_pkg::spg_byte_t d);
      glob_of = d[`SPG_GLOB_HI:`SPG_GLOB_LO];
   endfunction : glob_of

   spg_spi_if spi ();

   spg_spi_front u_front (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .cs_n_i(cs_n_i),
      .sck_i(sck_i),
      .si_i(si_i),
      .wp_n_i(wp_n_i),
      .spi(spi)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   spg_pkg::spg_cnt_t bit_cnt_r, bit_cnt_nxt;
   spg_pkg::spg_cnt_t byte_cnt_r, byte_cnt_nxt;
   spg_pkg::spg_byte_t shift_r, shift_nxt;
   spg_pkg::spg_byte_t opcode_r, opcode_nxt;
   spg_pkg::spg_byte_t data_r, data_nxt;
   logic [23:0] addr_r, addr_nxt;
   logic rd_act_r, rd_act_nxt;
   logic wel_r, wel_nxt;
   logic lock_r, lock_nxt;
   logic [`SPG_SEC_CNT-1:0] sect_r, sect_nxt;
   logic so_r, so_nxt;
   logic so_oe_r, so_oe_nxt;
   spg_pkg::spg_byte_t status_r, status_nxt;
   spg_pkg::spg_byte_t byte_in;
   logic wrsr_exec;
   logic [2:0] sec_idx;

   assign sec_idx = addr_r[`SPG_SEC_HI:`SPG_SEC_LO];

   always_comb begin
      bit_cnt_nxt = bit_cnt_r;
      byte_cnt_nxt = byte_cnt_r;
      shift_nxt = shift_r;
      opcode_nxt = opcode_r;
      data_nxt = data_r;
      addr_nxt = addr_r;
      rd_act_nxt = rd_act_r;
      wel_nxt = wel_r;
      lock_nxt = lock_r;
      sect_nxt = sect_r;
      so_nxt = so_r;
      so_oe_nxt = so_oe_r;
      wrsr_exec = 1'b0;
      byte_in = {shift_r[6:0], spi.sdi};
      if (spi.cs_end) begin
         bit_cnt_nxt = '0;
         byte_cnt_nxt = '0;
         rd_act_nxt = 1'b0;
         so_oe_nxt = 1'b0;
         // commands act only when deselected on a byte boundary
         if (bit_cnt_r == '0 && byte_cnt_r != '0) begin
            unique case (opcode_r)
               `SPG_OP_WRITE_ENABLE: wel_nxt = 1'b1;
               `SPG_OP_WRITE_DISABLE: wel_nxt = 1'b0;
               `SPG_OP_STATUS_WRITE: begin
                  // without the latch the write is dropped
                  wrsr_exec = wel_r && byte_cnt_r > `SPG_BYTE_DATA;
                  if (byte_cnt_r > `SPG_BYTE_DATA) wel_nxt = 1'b0;
               end
               default: ;
            endcase
         end
      end else if (spi.rise) begin
         shift_nxt = byte_in;
         bit_cnt_nxt = spg_pkg::spg_cnt_t'(bit_cnt_r + 3'h1);
         if (bit_cnt_r == `SPG_LAST_BIT) begin
            if (byte_cnt_r == `SPG_BYTE_OPCODE) opcode_nxt = byte_in;
            else if (byte_cnt_r <= `SPG_BYTE_ADDR_LAST)
               addr_nxt = {addr_r[15:0], byte_in};
            if (byte_cnt_r == `SPG_BYTE_DATA) data_nxt = byte_in;
            if (byte_cnt_r == `SPG_BYTE_ADDR_LAST &&
                opcode_r == `SPG_OP_PROT_READ) rd_act_nxt = 1'b1;
            if (byte_cnt_r != `SPG_BYTE_SAT)
               byte_cnt_nxt = spg_pkg::spg_cnt_t'(byte_cnt_r + 3'h1);
         end
      end
      // every bit of the repeating byte equals the sector bit,
      // so no bit position needs tracking
      if (spi.fall && rd_act_r && spi.sel) begin
         so_oe_nxt = 1'b1;
         so_nxt = sect_r[sec_idx];
      end
      if (wrsr_exec) begin
         if (!spi.wp_n && lock_r) begin
            lock_nxt = 1'b1;
         end else if (lock_r) begin
            // soft lock: global change needs a second write
            lock_nxt = data_r[`SPG_LOCK_BIT];
         end else begin
            lock_nxt = data_r[`SPG_LOCK_BIT];
            if (glob_of(data_r) == `SPG_GLOB_ALL_SET)
               sect_nxt = '1;
            else if (glob_of(data_r) == `SPG_GLOB_ALL_CLR)
               sect_nxt = '0;
         end
      end
      status_nxt = {lock_r, 2'b00, spi.wp_n, swp_of(sect_r),
                    wel_r, 1'b0};
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bit_cnt_r <= '0;
         byte_cnt_r <= '0;
         shift_r <= '0;
         opcode_r <= '0;
         data_r <= '0;
         addr_r <= '0;
         rd_act_r <= 1'b0;
         wel_r <= 1'b0;
         lock_r <= 1'b0;
         sect_r <= '1;
         so_r <= 1'b0;
         so_oe_r <= 1'b0;
         status_r <= `SPG_STAT_RESET;
      end else begin
         bit_cnt_r <= bit_cnt_nxt;
         byte_cnt_r <= byte_cnt_nxt;
         shift_r <= shift_nxt;
         opcode_r <= opcode_nxt;
         data_r <= data_nxt;
         addr_r <= addr_nxt;
         rd_act_r <= rd_act_nxt;
         wel_r <= wel_nxt;
         lock_r <= lock_nxt;
         sect_r <= sect_nxt;
         so_r <= so_nxt;
         so_oe_r <= so_oe_nxt;
         status_r <= status_nxt;
      end
   end

   assign so_o = so_r;
   assign so_oe_o = so_oe_r;
   assign status_o = status_r;
   assign sector_prot_o = sect_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   property p_glob_set;
      wrsr_exec && !lock_r && glob_of(data_r) == `SPG_GLOB_ALL_SET
         |=> &sect_r;
   endproperty
   a_glob_set: assert property (p_glob_set)
      else $error("global protect did not set all sectors");

   property p_glob_clr;
      wrsr_exec && !lock_r && glob_of(data_r) == `SPG_GLOB_ALL_CLR
         |=> sect_r == '0 && !lock_r == !$past(data_r[`SPG_LOCK_BIT]);
   endproperty
   a_glob_clr: assert property (p_glob_clr)
      else $error("global unprotect failed");

   property p_mixed;
      wrsr_exec && glob_of(data_r) != `SPG_GLOB_ALL_SET &&
         glob_of(data_r) != `SPG_GLOB_ALL_CLR |=> $stable(sect_r);
   endproperty
   a_mixed: assert property (p_mixed)
      else $error("mixed pattern changed sectors");

   property p_hw_lock;
      wrsr_exec && !spi.wp_n && lock_r |=> lock_r && $stable(sect_r);
   endproperty
   a_hw_lock: assert property (p_hw_lock)
      else $error("hardware lock violated");

   property p_soft_lock;
      wrsr_exec && spi.wp_n && lock_r
         |=> $stable(sect_r) && lock_r == $past(data_r[`SPG_LOCK_BIT]);
   endproperty
   a_soft_lock: assert property (p_soft_lock)
      else $error("soft lock handling wrong");

   property p_lock_store;
      wrsr_exec && !lock_r |=> lock_r == $past(data_r[`SPG_LOCK_BIT]);
   endproperty
   a_lock_store: assert property (p_lock_store)
      else $error("lock bit not stored from bit 7");

   property p_wel_gate;
      spi.cs_end && opcode_r == `SPG_OP_STATUS_WRITE && !wel_r
         |=> $stable(lock_r) && $stable(sect_r);
   endproperty
   a_wel_gate: assert property (p_wel_gate)
      else $error("status write ran without write latch");

   property p_rd_data;
      so_oe_r && $past(spi.fall) |-> so_r == $past(sect_r[sec_idx]);
   endproperty
   a_rd_data: assert property (p_rd_data)
      else $error("read output not the sector bit");

   property p_cs_end;
      spi.cs_end |=> !so_oe_r [*2];
   endproperty
   a_cs_end: assert property (p_cs_end)
      else $error("output still driven after deselect");

   property p_hiz;
      so_oe_r && !$past(so_oe_r) |-> $past(rd_act_r);
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("output driven before address complete");

   property p_swp;
      ##1 status_r[3:2] == swp_of($past(sect_r));
   endproperty
   a_swp: assert property (p_swp)
      else $error("summary field wrong");

   c_glob_set: cover property (wrsr_exec && !lock_r &&
      glob_of(data_r) == `SPG_GLOB_ALL_SET);
   c_unlock: cover property (wrsr_exec && lock_r && spi.wp_n);
   c_read: cover property (so_oe_r ##1 spi.cs_end);
   c_hw_lock: cover property (wrsr_exec && lock_r && !spi.wp_n);
endmodule : spg_prot_ctrl

/* rtl/spg_spi_front.sv */
`timescale 1ns/100ps
`include "spg_params.svh"
module spg_spi_front (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic si_i,
   input wire logic wp_n_i,
   spg_spi_if.front spi
);
   // ----------------------------------------------------------------
   // two-stage synchronisers, then one more stage for edge finding
   // ----------------------------------------------------------------
   // bit order: 3 cs_n, 2 sck, 1 si, 0 wp_n
   logic [3:0] meta_r;
   logic [3:0] meta_nxt;
   logic [3:0] sync_r;
   logic [3:0] sync_nxt;
   logic [1:0] prev_r;
   logic [1:0] prev_nxt;

   always_comb begin
      meta_nxt = {cs_n_i, sck_i, si_i, wp_n_i};
      sync_nxt = meta_r;
      prev_nxt = sync_r[3:2];
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         // sck resets to its idle level so no false edge follows reset
         meta_r <= `SPG_SYNC_RESET;
         sync_r <= `SPG_SYNC_RESET;
         prev_r <= `SPG_EDGE_RESET;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
      end
   end

   // si and sck travel through matching stages, so si is taken
   // with the same sck edge the host launched it for
   assign spi.sel = !sync_r[3];
   assign spi.rise = !sync_r[3] && sync_r[2] && !prev_r[0];
   assign spi.fall = !sync_r[3] && !sync_r[2] && prev_r[0];
   assign spi.sdi = sync_r[1];
   assign spi.cs_end = sync_r[3] && !prev_r[1];
   assign spi.wp_n = sync_r[0];
endmodule : spg_spi_front

/* rtl/spg_spi_if.sv */
`timescale 1ns/100ps
interface spg_spi_if;
   logic sel;
   logic rise;
   logic fall;
   logic sdi;
   logic cs_end;
   logic wp_n;
   modport front (output sel, rise, fall, sdi, cs_end, wp_n);
   modport core (input sel, rise, fall, sdi, cs_end, wp_n);
endinterface : spg_spi_if

/* testbench/spg_host_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// spi host, mode 0, sck idle low between frames
// ----------------------------------------------------------------
module spg_host_model (
   input wire logic clk_i,
   input wire logic so_i,
   input wire logic so_oe_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic si_o,
   output int oe_bad_o
);
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
      oe_bad_o = 0;
   end

   // half of the 320 ns link period is four system clocks
   task automatic half;
      repeat (4) @(posedge clk_i);
   endtask : half

   // so is taken at the next fall: it stands a whole sck period
   task automatic frame(input logic [31:0] d, input int nb, input int rd,
      output logic [7:0] q);
      q = 8'h00;
      cs_n_o <= 1'b0;
      half();
      for (int i = 0; i < nb; i++) begin
         sck_o <= 1'b0;
         si_o <= d[nb-1-i];
         half();
         if (so_oe_i !== 1'b0) oe_bad_o++;
         sck_o <= 1'b1;
         half();
      end
      for (int j = 0; j <= rd; j++) begin
         if (j > 0) q = {q[6:0], so_i};
         if (j > 0 && so_oe_i !== 1'b1) oe_bad_o++;
         if (j < rd) begin
            sck_o <= 1'b0;
            half();
            sck_o <= 1'b1;
            half();
         end
      end
      sck_o <= 1'b0;
      half();
      cs_n_o <= 1'b1;
      // a released line must not look like it still holds the last bit
      si_o <= ~si_o;
      half();
      half();
   endtask : frame
endmodule : spg_host_model

/* testbench/spg_prot_ctrl_tb.sv */
`timescale 1ns/100ps
module spg_prot_ctrl_tb;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic wp_n = 1'b1;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe;
   logic [7:0] status;
   logic [7:0] sec;
   logic [7:0] q;
   logic [7:0] mix [4] = '{8'h04, 8'h38, 8'h54, 8'h3B};
   int oe_bad;
   int n_fail = 0;
   int total_checks = 0;

   always #20 clk_i = ~clk_i;

   spg_prot_ctrl dut (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n),
      .sck_i(sck), .si_i(si), .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe),
      .status_o(status), .sector_prot_o(sec));

   spg_host_model host (.clk_i(clk_i), .so_i(so), .so_oe_i(so_oe),
      .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .oe_bad_o(oe_bad));

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // en selects a write-enable frame first; el/es are the expected
   // lock bit and sector bits after the write
   task automatic wrsr(input logic [7:0] v, input logic en,
      input logic el, input logic [7:0] es);
      logic [1:0] soft_protect_summary;
      if (en) host.frame({24'h00_0000, 8'h06}, 8, 0, q);
      host.frame({16'h0000, 8'h01, v}, 16, 0, q);
      soft_protect_summary = (es == 8'hFF) ? 2'h3 : ((es == 8'h00) ? 2'h0 : 2'h1);
      chk("sectors", es, sec);
      chk("status", {el, 2'b00, wp_n, soft_protect_summary, 2'b00}, status);
   endtask : wrsr

   // twelve bits read: the last eight show the byte repeating
   task automatic rd(input logic [23:0] a, input logic [7:0] exp);
      host.frame({8'h3C, a}, 32, 12, q);
      chk("prot_read", exp, q);
   endtask : rd

   task automatic wrap_up;
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (60000) @(posedge clk_i);
      n_fail++;
      wrap_up();
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk("sectors", 8'hFF, sec);
      chk("status", 8'h1C, status);
      wrsr(8'h00, 1'b0, 1'b0, 8'hFF);
      wrsr(8'h00, 1'b1, 1'b0, 8'h00);
      rd(24'h03_0000, 8'h00);
      for (int i = 0; i < 4; i++) wrsr(mix[i], 1'b1, 1'b0, 8'h00);
      wrsr(8'h7F, 1'b1, 1'b0, 8'hFF);
      rd(24'h05_1234, 8'hFF);
      for (int i = 0; i < 4; i++) wrsr(mix[i], 1'b1, 1'b0, 8'hFF);
      $display("test global done");
      wrsr(8'hF0, 1'b1, 1'b1, 8'hFF);
      wrsr(8'h00, 1'b1, 1'b0, 8'hFF);
      wrsr(8'h00, 1'b1, 1'b0, 8'h00);
      wrsr(8'hF0, 1'b1, 1'b1, 8'h00);
      wrsr(8'hBC, 1'b1, 1'b1, 8'h00);
      wrsr(8'h0F, 1'b1, 1'b0, 8'h00);
      $display("test soft lock done");
      wrsr(8'hFF, 1'b1, 1'b1, 8'hFF);
      wp_n <= 1'b0;
      wrsr(8'h00, 1'b1, 1'b1, 8'hFF);
      wrsr(8'h0F, 1'b1, 1'b1, 8'hFF);
      rd(24'h07_FFFF, 8'hFF);
      wp_n <= 1'b1;
      wrsr(8'h0F, 1'b1, 1'b0, 8'hFF);
      wrsr(8'h00, 1'b1, 1'b0, 8'h00);
      rd(24'h00_0000, 8'h00);
      $display("test hard lock done");
      // latch shows in status, write disable drops it again
      host.frame({24'h00_0000, 8'h06}, 8, 0, q);
      chk("status", 8'h12, status);
      host.frame({24'h00_0000, 8'h04}, 8, 0, q);
      chk("status", 8'h10, status);
      wrsr(8'h7F, 1'b0, 1'b0, 8'h00);
      $display("test latch done");
      host.frame({8'h3C, 24'h02_0000}, 32, 3, q);
      chk("so_enable", 8'h00, {7'h00, so_oe});
      chk("oe_errors", 8'h00, oe_bad[7:0]);
      $display("test abort done");
      wrap_up();
   end
endmodule : spg_prot_ctrl_tb
